// File: rtl/rsbc_top.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "rsbc_defines.svh"
module rsbc_top
    import rsbc_pkg::*;
#(
    parameter int CFG_W = 16
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             sw_reset,
    input  wire logic             wdt_reset,
    input  wire logic             end_of_init_instruction,
    input  wire logic             boot_source_select,
    input  wire logic [CFG_W-1:0] boot_config_port_a,
    input  wire logic             rd_strobe_pin,
    input  wire logic             ale_strobe_pin,
    input  wire logic             wr_strobe_pin,
    input  wire logic             debug_rst,
    input  wire logic [3:0]       reg_addr,
    input  wire logic [15:0]      reg_wdata,
    input  wire logic             reg_write,
    input  wire logic             reg_read,
    output logic      [15:0]      reg_rdata,
    output logic                  reset_indication_out,
    output logic                  boot_external,
    output logic      [CFG_W:0]   boot_config,
    output logic                  debug_active,
    output logic                  internal_reset
);
    // internal boot packs three strap bits, so narrower ports cannot serve
    if (CFG_W < 3) begin : g_bad_cfg_w
        $error("rsbc_top: CFG_W must be at least 3");
    end

    typedef struct packed {
        rsbc_state_t      st;
        logic             ind;
        logic             lock;
        logic             ext_boot;
        logic [CFG_W:0]   cfg;
        logic [3:0]       ctrl;
        logic [15:0]      prot;
        logic             dbg;
        logic             int_rst;
        logic [15:0]      rdata;
    } rsbc_regs_t;

    rsbc_regs_t s_reg;
    rsbc_regs_t s_next;
    logic       soft_rst;

    // soft/watchdog resets pulse one cycle, handled as synchronous entry
    assign soft_rst = sw_reset || wdt_reset;

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 16'h0000;
        s_next.int_rst = 1'b0;
        s_next.dbg = debug_rst;
        case (s_reg.st)
            RSBC_IN_RESET: begin
                s_next.st = RSBC_INIT;
                // capture boot straps at the first edge after release
                if (!boot_source_select) begin
                    s_next.ext_boot = 1'b1;
                    s_next.cfg = {rd_strobe_pin, boot_config_port_a};
                end else begin
                    s_next.ext_boot = 1'b0;
                    s_next.cfg = {{(CFG_W-2){1'b0}}, rd_strobe_pin,
                                  ale_strobe_pin, wr_strobe_pin};
                end
                if (s_reg.ctrl[`RSBC_CTRL_EOR_REL]) begin
                    s_next.ind = 1'b0;
                end
            end
            RSBC_INIT: begin
                if (end_of_init_instruction) begin
                    s_next.ind = 1'b0;
                    s_next.lock = 1'b1;
                    s_next.st = RSBC_RUN;
                end
            end
            RSBC_RUN: begin
            end
            default: begin
                s_next.st = RSBC_INIT;
            end
        endcase
        if (reg_write) begin
            case (reg_addr)
                `RSBC_ADDR_CTRL: begin
                    s_next.ctrl = reg_wdata[3:0];
                    if (reg_wdata[`RSBC_CTRL_SW_REL] && !s_reg.lock) begin
                        s_next.ind = 1'b0;
                    end
                end
                `RSBC_ADDR_PROT: begin
                    if (!s_reg.lock) begin
                        s_next.prot = reg_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        if (reg_read) begin
            case (reg_addr)
                `RSBC_ADDR_CTRL:    s_next.rdata = {12'h000, s_reg.ctrl};
                `RSBC_ADDR_STATUS:  s_next.rdata = {12'h000, s_reg.dbg,
                                        s_reg.ext_boot, s_reg.lock, s_reg.ind};
                `RSBC_ADDR_BOOTCFG: s_next.rdata = 16'(s_reg.cfg);
                `RSBC_ADDR_PROT:    s_next.rdata = s_reg.prot;
                default:            s_next.rdata = 16'h0000;
            endcase
        end
        if ((sw_reset && s_reg.ctrl[`RSBC_CTRL_SWRST_EN]) ||
            (wdt_reset && s_reg.ctrl[`RSBC_CTRL_WDRST_EN])) begin
            s_next.ind = 1'b1;
        end
        if (soft_rst) begin
            s_next.st = RSBC_IN_RESET;
            s_next.lock = 1'b0;
            s_next.int_rst = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_reg.st <= RSBC_IN_RESET;
            s_reg.ind <= 1'b1;
            s_reg.lock <= 1'b0;
            s_reg.ext_boot <= 1'b0;
            s_reg.cfg <= '0;
            s_reg.ctrl <= `RSBC_CTRL_RESET;
            s_reg.prot <= `RSBC_PROT_RESET;
            s_reg.dbg <= 1'b0;
            s_reg.int_rst <= 1'b0;
            s_reg.rdata <= 16'h0000;
        end else begin
            s_reg <= s_next;
        end
    end

    // raw reset term keeps the pin asserted before any clock edge
    assign reset_indication_out = !rst_b || s_reg.ind;
    assign boot_external = s_reg.ext_boot;
    assign boot_config = s_reg.cfg;
    assign debug_active = s_reg.dbg;
    assign internal_reset = s_reg.int_rst;
    assign reg_rdata = s_reg.rdata;

    chk_rst_ind: assert property (@(posedge clock)
        !rst_b |-> reset_indication_out)
        else $error("indication low during reset");
    chk_eoi_release: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.st == RSBC_INIT && end_of_init_instruction && !soft_rst)
        |=> !reset_indication_out && s_reg.lock)
        else $error("end of init did not release and lock");
    chk_sw_assert: assert property (@(posedge clock) disable iff (!rst_b)
        (sw_reset && s_reg.ctrl[`RSBC_CTRL_SWRST_EN]) |=> reset_indication_out)
        else $error("software reset did not assert indication");
    chk_ext_boot: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.st == RSBC_IN_RESET && !boot_source_select) |=> boot_external)
        else $error("external boot not taken");
    chk_int_boot: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.st == RSBC_IN_RESET && boot_source_select && !soft_rst)
        |=> !boot_external && boot_config[0] == $past(wr_strobe_pin))
        else $error("internal boot config wrong");
    chk_cfg_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.st != RSBC_IN_RESET) |=> $stable(boot_config))
        else $error("boot config changed after capture");
    chk_lock_prot: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.lock && !soft_rst) |=> $stable(s_reg.prot))
        else $error("protected register changed after lock");
    chk_debug: assert property (@(posedge clock) disable iff (!rst_b)
        debug_rst |=> debug_active)
        else $error("debug not activated");

    // multi-step behaviours are built from these named steps
    sequence s_sw_hit;
        sw_reset && s_reg.ctrl[`RSBC_CTRL_SWRST_EN];
    endsequence

    sequence s_wdt_hit;
        wdt_reset && s_reg.ctrl[`RSBC_CTRL_WDRST_EN];
    endsequence

    sequence s_capture;
        s_reg.st == RSBC_IN_RESET && !soft_rst;
    endsequence

    sequence s_eor_capture;
        s_reg.st == RSBC_IN_RESET && s_reg.ctrl[`RSBC_CTRL_EOR_REL]
            && !soft_rst;
    endsequence

    sequence s_reentered;
        s_reg.st == RSBC_IN_RESET && internal_reset && !s_reg.lock;
    endsequence

    sequence s_reenter_clean;
        soft_rst ##1 !soft_rst;
    endsequence

    chk_wdt_assert: assert property (@(posedge clock) disable iff (!rst_b)
        s_wdt_hit |=> reset_indication_out)
        else $error("watchdog reset did not assert indication");

    chk_sw_unsel: assert property (@(posedge clock) disable iff (!rst_b)
        (!s_reg.ind && sw_reset && !wdt_reset &&
         !s_reg.ctrl[`RSBC_CTRL_SWRST_EN]) |=> !reset_indication_out)
        else $error("unselected software reset asserted indication");

    chk_eor_release: assert property (@(posedge clock) disable iff (!rst_b)
        s_eor_capture |=> !reset_indication_out)
        else $error("end of reset release not taken");

    chk_sw_release: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_write && reg_addr == `RSBC_ADDR_CTRL && !soft_rst &&
         reg_wdata[`RSBC_CTRL_SW_REL] && !s_reg.lock)
        |=> !reset_indication_out)
        else $error("software release not taken");

    chk_run_ind: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.st == RSBC_RUN && !soft_rst) |=> !reset_indication_out)
        else $error("indication active after end of init");

    chk_reenter: assert property (@(posedge clock) disable iff (!rst_b)
        soft_rst |=> s_reentered)
        else $error("internal reset did not re-enter reset state");

    chk_capture_next: assert property (@(posedge clock) disable iff (!rst_b)
        s_capture |=> s_reg.st == RSBC_INIT)
        else $error("capture did not move on to init");

    chk_reenter_init: assert property (@(posedge clock) disable iff (!rst_b)
        s_reenter_clean |=> s_reg.st == RSBC_INIT)
        else $error("soft reset did not recapture straps");

    chk_irst_idle: assert property (@(posedge clock) disable iff (!rst_b)
        !soft_rst |=> !internal_reset)
        else $error("internal reset pulse without cause");

    chk_ext_cfg: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.st == RSBC_IN_RESET && !boot_source_select)
        |=> boot_config[CFG_W] == $past(rd_strobe_pin) &&
            boot_config[CFG_W-1:0] == $past(boot_config_port_a))
        else $error("external boot config wrong");

    chk_int_cfg_hi: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.st == RSBC_IN_RESET && boot_source_select)
        |=> boot_config[CFG_W:3] == '0)
        else $error("internal boot config upper bits set");

    chk_lock_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.lock && !soft_rst) |=> s_reg.lock)
        else $error("lock dropped without reset");

    chk_prot_write: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_write && reg_addr == `RSBC_ADDR_PROT && !s_reg.lock)
        |=> s_reg.prot == $past(reg_wdata))
        else $error("protected register write lost before lock");

    chk_prot_read: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_read && !reg_write && reg_addr == `RSBC_ADDR_PROT)
        |=> reg_rdata == s_reg.prot)
        else $error("protected register read wrong");

    chk_rdata_idle: assert property (@(posedge clock) disable iff (!rst_b)
        !reg_read |=> reg_rdata == 16'h0000)
        else $error("read data not zero when idle");

    chk_unmapped_rd: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_read && reg_addr > `RSBC_ADDR_PROT) |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");

    chk_ctrl_keep: assert property (@(posedge clock) disable iff (!rst_b)
        (soft_rst && !reg_write) |=> $stable(s_reg.ctrl))
        else $error("control lost on internal reset");

    chk_init_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.st == RSBC_INIT && !end_of_init_instruction && !soft_rst)
        |=> s_reg.st == RSBC_INIT)
        else $error("init left without end of init");

    chk_run_stay: assert property (@(posedge clock) disable iff (!rst_b)
        (s_reg.st == RSBC_RUN && !soft_rst) |=> s_reg.st == RSBC_RUN)
        else $error("run state left without reset");

    chk_debug_off: assert property (@(posedge clock) disable iff (!rst_b)
        !debug_rst |=> !debug_active)
        else $error("debug active while input low");
endmodule

// File: rtl/rsbc_defines.svh
`ifndef RSBC_DEFINES_SVH
`define RSBC_DEFINES_SVH
`define RSBC_ADDR_CTRL     4'h0
`define RSBC_ADDR_STATUS   4'h1
`define RSBC_ADDR_BOOTCFG  4'h2
`define RSBC_ADDR_PROT     4'h3
`define RSBC_CTRL_SWRST_EN 0
`define RSBC_CTRL_WDRST_EN 1
`define RSBC_CTRL_EOR_REL  2
`define RSBC_CTRL_SW_REL   3
`define RSBC_ST_IND        0
`define RSBC_ST_LOCK       1
`define RSBC_ST_EXT_BOOT   2
`define RSBC_ST_DEBUG      3
`define RSBC_CTRL_RESET    4'h0
`define RSBC_PROT_RESET    16'h0000
`endif

// File: rtl/rsbc_pkg.sv
package rsbc_pkg;
    typedef enum logic [1:0] {
        RSBC_IN_RESET,
        RSBC_INIT,
        RSBC_RUN
    } rsbc_state_t;
endpackage

// File: dv/rsbc_board.sv
`timescale 1ns/10ps
module rsbc_board #(
    parameter bit ROMLESS = 1'b0
) (
    input  wire logic        int_boot_req,
    input  wire logic        dbg_req,
    output logic             boot_source_select,
    output logic [15:0]      port_a,
    output logic             rd_pin,
    output logic             ale_pin,
    output logic             wr_pin,
    output logic             debug_rst
);
    // parts without program memory never see the strap high
    assign boot_source_select = ROMLESS ? 1'b0 : int_boot_req;
    assign debug_rst          = dbg_req;
    assign port_a             = 16'hA5C3;
    assign rd_pin             = 1'b1;
    assign ale_pin            = 1'b0;
    assign wr_pin             = 1'b1;
endmodule

// File: dv/test_rsbc_top.sv
`timescale 1ns/10ps
module test_rsbc_top;
    logic        clock = 1'b0, rst_b = 1'b0, sw = 1'b0, wdt = 1'b0;
    logic        eoi = 1'b0, int_req = 1'b0, dbg_req = 1'b0;
    logic        reg_write = 1'b0, reg_read = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, port_a, rv;
    logic        sel, rd_pin, ale_pin, wr_pin, debug_rst;
    logic        rio, boot_ext, dbg_act, irst;
    logic [16:0] boot_cfg;
    int          errors = 0, cmp_count = 0;

    always #50 clock = ~clock;

    rsbc_board BOARD (.int_boot_req(int_req), .dbg_req(dbg_req),
        .boot_source_select(sel), .port_a(port_a), .rd_pin(rd_pin),
        .ale_pin(ale_pin), .wr_pin(wr_pin), .debug_rst(debug_rst));

    rsbc_top #(.CFG_W(16)) DUT (.clock(clock), .rst_b(rst_b),
        .sw_reset(sw), .wdt_reset(wdt), .end_of_init_instruction(eoi),
        .boot_source_select(sel), .boot_config_port_a(port_a),
        .rd_strobe_pin(rd_pin), .ale_strobe_pin(ale_pin),
        .wr_strobe_pin(wr_pin), .debug_rst(debug_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .reset_indication_out(rio), .boot_external(boot_ext),
        .boot_config(boot_cfg), .debug_active(dbg_act),
        .internal_reset(irst));

    task automatic chk(string what, logic [16:0] exp, logic [16:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    task automatic give_verdict;
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic t_lock;
        wr(4'h3, 16'h1234);
        rd(4'h3);
        chk("prot", 16'h1234, rv);
        @(posedge clock) eoi <= 1'b1;
        @(posedge clock) eoi <= 1'b0;
        #1 chk("ind_eoi", 0, rio);
        wr(4'h3, 16'h5555);
        rd(4'h3);
        chk("prot_lock", 16'h1234, rv);
        rd(4'hF);
        chk("unmapped", 0, rv);
    endtask

    task automatic t_soft;
        int_req <= 1'b1;
        wr(4'h0, 16'h0001);
        @(posedge clock) sw <= 1'b1;
        @(posedge clock) sw <= 1'b0;
        #1 chk("irst_sw", 1, irst);
        chk("ind_sw_now", 1, rio);
        repeat (3) @(posedge clock);
        #1 chk("ind_sw", 1, rio);
        chk("irst_off", 0, irst);
        chk("int_boot", 0, boot_ext);
        chk("cfg_int", 3'b101, boot_cfg[2:0]);
        rd(4'h1);
        chk("status", 16'h0001, rv);
        wr(4'h0, 16'h0008);
        chk("ind_swrel", 0, rio);
        wr(4'h0, 16'h0006);
        @(posedge clock) wdt <= 1'b1;
        @(posedge clock) wdt <= 1'b0;
        #1 chk("ind_wdt", 1, rio);
        chk("irst_wdt", 1, irst);
        repeat (4) @(posedge clock);
        #1 chk("ind_eor", 0, rio);
        dbg_req <= 1'b1;
        repeat (2) @(posedge clock);
        #1 chk("debug", 1, dbg_act);
        dbg_req <= 1'b0;
    endtask

    initial begin
        #1 chk("ind_rst", 1, rio);
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        #1 chk("ext_boot", 1, boot_ext);
        chk("cfg_ext", {1'b1, 16'hA5C3}, boot_cfg);
        t_lock();
        t_soft();
        give_verdict();
    end

    initial begin
        #20000;
        errors++;
        give_verdict();
    end
endmodule
